//--- ctt_regs.vh
`ifndef CTT_REGS_VH
`define CTT_REGS_VH

// Register offsets (byte addresses)
`define CTT_OFS_CTRL       4'h0
`define CTT_OFS_STATUS     4'h4
`define CTT_OFS_PRE_CNT    4'h8
`define CTT_OFS_FAST_CNT   4'hC

// Control register fields
`define CTT_CTRL_EN        0
`define CTT_CTRL_RUN       1
`define CTT_CTRL_HV        2
`define CTT_CTRL_SCL_LSB   3
`define CTT_CTRL_SCL_MSB   4
`define CTT_CTRL_VSAFE     5
`define CTT_CTRL_RST       6'h23

// Status register fields
`define CTT_ST_CODE_LSB    0
`define CTT_ST_CODE_MSB    1
`define CTT_ST_FAULT       2
`define CTT_ST_PULLUP      3
`define CTT_ST_DONE        4
`define CTT_ST_OFF         5
`define CTT_ST_SLOW        6
`define CTT_ST_SUSP        7

// Reported charge state codes
`define CTT_CODE_IDLE      2'h0
`define CTT_CODE_DONE      2'h1
`define CTT_CODE_FAST      2'h2
`define CTT_CODE_PRE       2'h3

// Time base: one timer tick per period, in ns, at a 8 ns clock
`define CTT_CLK_NS         8
`define CTT_TICK_NS        1000000
`define CTT_TICK_CYC       (`CTT_TICK_NS / `CTT_CLK_NS)
`define CTT_INT_TICK_NS    1000000
`define CTT_INT_TICK_CYC   (`CTT_INT_TICK_NS / `CTT_CLK_NS)
// Fast-charge timeout in ticks; pre-charge is a tenth of it
`define CTT_FAST_TICKS     18000
`define CTT_PRE_DIV        10
// Sensed set-pin level: full scale means no slowdown, half scale is the floor
`define CTT_LVL_FULL       9'h100
`define CTT_LVL_MIN        8'h80

`endif

//--- ctt_sync.v
// Three-stage synchroniser; output follows once stages two and three agree
module ctt_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clock_i,
    input  wire         rst_n_i,
    // Data
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);

    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;

    // First stage feeds only the second, to keep metastability contained
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_ff  <= {W{1'b0}};
            s2_ff  <= {W{1'b0}};
            s3_ff  <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end
        else
        begin
            s1_ff  <= async_i;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            sync_o <= ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & sync_o);
        end
    end

endmodule // ctt_sync

//--- ctt_charger_ctrl.v
// Our own choices: the plain strobed port and the register addresses.
`include "ctt_regs.vh"

// Behaviour
// R1: Terminate when current below tenth of rate
// R2: Scale code sets current and termination alike
// R3: After done, restart when battery below recharge
// R4: Enable/run toggle or input cycling restarts charge
// R5: No termination during thermal, droop or supplement
// R6: High voltage only if select set, safety clear
// R7: No input detected means low-power off
// R8: Pre-charge timeout is tenth of fast timeout
// R9: Suspend freezes both timers without resetting
// R10: Pre-charge expiry below threshold gives fault, off
// R11: Fast timer starts when preconditioning ends
// R12: Fast expiry without termination gives fault, off
// R13: Floating timer pin holds fast timer reset
// R14: Fault above recharge waits drop, then restarts
// R15: Fault below recharge enables pullup until above
// R16: New cycle or undervoltage resets timers, faults
// R17: Slowdown rules for pre-charge and fast timers
// R18: Slowed tick stretches by ratio, at most double
// R19: Added time capped at twice nominal timeout
// R20: Start needs input, enable, run, low battery
// R21: Report two-bit state code
// R22: Synchronise comparators, count on prescaled tick
module ctt_charger_ctrl #(
    parameter TICK_CYC     = `CTT_TICK_CYC,
    parameter INT_TICK_CYC = `CTT_INT_TICK_CYC,
    parameter FAST_TICKS   = `CTT_FAST_TICKS
) (
    // Clock and reset
    input  wire       clock_i,
    input  wire       rst_n_i,
    // Register port
    input  wire [3:0] addr_i,
    input  wire [7:0] wr_data_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rd_data_o,
    // Analog comparators and loop status (asynchronous)
    input  wire       term_cmp_i,
    input  wire       vreg_phase_i,
    input  wire       bat_below_rch_i,
    input  wire       bat_above_pre_i,
    input  wire       thermal_loop_i,
    input  wire       input_droop_loop_i,
    input  wire       supplement_i,
    input  wire       ac_det_i,
    input  wire       usb_det_i,
    input  wire       uvlo_i,
    input  wire       tmr_float_i,
    input  wire       temp_fault_i,
    // Sensed set-pin level relative to reference, same clock domain
    input  wire [7:0] set_level_i,
    // Charger controls
    output reg        charge_on_o,
    output reg        hv_charge_o,
    output reg  [1:0] current_scale_o,
    output reg        pullup_en_o,
    output reg        low_power_off_o,
    // Status
    output reg        charge_state_high_o,
    output reg        charge_state_low_o,
    output reg        fault_o
);

    localparam PRE_TICKS = FAST_TICKS / `CTT_PRE_DIV;

    // FSM states
    localparam ST_OFF   = 3'd0;
    localparam ST_WAIT  = 3'd1;
    localparam ST_PRE   = 3'd2;
    localparam ST_FAST  = 3'd3;
    localparam ST_DONE  = 3'd4;
    localparam ST_FAULT = 3'd5;

    wire [11:0] cmp_s;
    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [5:0]  ctrl_ff;
    reg  [1:0]  enrun_d_ff;
    reg  [23:0] pre_cnt_ff;
    reg  [23:0] fast_cnt_ff;
    reg  [24:0] added_ff;
    reg  [8:0]  acc_ff;
    reg  [23:0] presc_ff;
    reg         base_tick_ff;
    reg         seen_above_ff;
    reg         new_cycle;

    // R22
    ctt_sync #(
        .W (12)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({term_cmp_i, vreg_phase_i, bat_below_rch_i, bat_above_pre_i,
                   thermal_loop_i, input_droop_loop_i, supplement_i, ac_det_i,
                   usb_det_i, uvlo_i, tmr_float_i, temp_fault_i}),
        .sync_o  (cmp_s)
    );

    wire term_s    = cmp_s[11];
    wire vreg_s    = cmp_s[10];
    wire rch_low_s = cmp_s[9];
    wire pre_ok_s  = cmp_s[8];
    wire loop_s    = cmp_s[7] | cmp_s[6];
    wire supp_s    = cmp_s[5];
    wire in_s      = cmp_s[4] | cmp_s[3];  // R7
    wire uvlo_s    = cmp_s[2];
    wire float_s   = cmp_s[1];
    wire tfault_s  = cmp_s[0];

    wire en_run    = ctrl_ff[`CTT_CTRL_EN] & ctrl_ff[`CTT_CTRL_RUN];
    wire run_rise  = en_run & ~enrun_d_ff[1];
    wire en_fall   = enrun_d_ff[0] & ~ctrl_ff[`CTT_CTRL_EN];
    wire suspend   = ~ctrl_ff[`CTT_CTRL_RUN] | tfault_s;  // R9
    wire term_ok   = vreg_s & term_s & ~loop_s & ~supp_s;  // R1 R5

    // Slowdown applies per phase; added time beyond twice nominal is refused
    wire slow_pre  = (state_ff == ST_PRE) & loop_s;  // R17
    wire slow_fast = (state_ff == ST_FAST) & loop_s & rch_low_s;  // R17
    wire slowing   = (slow_pre | slow_fast) &
                     (added_ff < ((state_ff == ST_PRE) ? 2 * PRE_TICKS : 2 * FAST_TICKS));  // R19
    wire [7:0] lvl = (set_level_i < `CTT_LVL_MIN) ? `CTT_LVL_MIN : set_level_i;  // R18
    wire [8:0] acc_sum = acc_ff + {1'b0, lvl};
    wire timer_tick = base_tick_ff & ~suspend & (~slowing | (acc_sum >= `CTT_LVL_FULL));

    wire pre_exp  = (pre_cnt_ff >= PRE_TICKS);  // R8
    wire fast_exp = ~float_s & (fast_cnt_ff >= FAST_TICKS);

    // Prescaler; floating timer pin swaps to the internal time base
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            presc_ff     <= 24'h000000;
            base_tick_ff <= 1'b0;
        end
        else
        begin
            base_tick_ff <= 1'b0;
            if (presc_ff >= (float_s ? INT_TICK_CYC - 1 : TICK_CYC - 1))  // R13
            begin
                presc_ff     <= 24'h000000;
                base_tick_ff <= 1'b1;  // R22
            end
            else
            begin
                presc_ff <= presc_ff + 24'h000001;
            end
        end
    end

    // Register writes; enable/run history detects toggles
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_ff    <= `CTT_CTRL_RST;
            enrun_d_ff <= 2'h0;
        end
        else
        begin
            enrun_d_ff <= {en_run, ctrl_ff[`CTT_CTRL_EN]};
            if (wr_i && addr_i == `CTT_OFS_CTRL)
            begin
                ctrl_ff <= wr_data_i[5:0];
            end
        end
    end

    // Next state
    always @*
    begin
        nxt_state = state_ff;
        new_cycle = 1'b0;
        case (state_ff)
            ST_OFF:
            begin
                if (in_s)
                begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (en_run && rch_low_s)  // R20
                begin
                    nxt_state = pre_ok_s ? ST_FAST : ST_PRE;
                end
            end
            ST_PRE:
            begin
                if (pre_exp && !pre_ok_s)
                begin
                    nxt_state = ST_FAULT;  // R10
                end
                else if (pre_ok_s && !suspend)
                begin
                    nxt_state = ST_FAST;  // R11
                end
            end
            ST_FAST:
            begin
                if (term_ok && !suspend)
                begin
                    nxt_state = ST_DONE;
                end
                else if (fast_exp)
                begin
                    nxt_state = ST_FAULT;  // R12
                end
            end
            ST_DONE:
            begin
                if (rch_low_s || run_rise)  // R3 R4
                begin
                    new_cycle = 1'b1;
                    nxt_state = ST_WAIT;
                end
            end
            ST_FAULT:
            begin
                if ((seen_above_ff && rch_low_s) || run_rise)  // R14 R4
                begin
                    new_cycle = 1'b1;
                    nxt_state = ST_WAIT;
                end
            end
            default:
            begin
                nxt_state = ST_OFF;
            end
        endcase
        // Loss of input and undervoltage override everything; enable drop overrides all else
        if (!in_s || uvlo_s)
        begin
            nxt_state = ST_OFF;  // R7 R16
        end
        else if (en_fall && state_ff != ST_OFF)
        begin
            nxt_state = ST_WAIT;  // R4
        end
    end

    // State, fault recovery and pullup
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff      <= ST_OFF;
            seen_above_ff <= 1'b0;
            pullup_en_o   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state == ST_FAULT && state_ff != ST_FAULT)
            begin
                seen_above_ff <= ~rch_low_s;
                pullup_en_o   <= rch_low_s;  // R15
            end
            else if (state_ff == ST_FAULT && nxt_state == ST_FAULT)
            begin
                if (!rch_low_s)
                begin
                    seen_above_ff <= 1'b1;  // R15
                end
                pullup_en_o <= rch_low_s & ~seen_above_ff;  // R15
            end
            else
            begin
                pullup_en_o <= 1'b0;
            end
        end
    end

    // Safety timers: cleared on any fresh start, frozen while suspended
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre_cnt_ff  <= 24'h000000;
            fast_cnt_ff <= 24'h000000;
            added_ff    <= 25'h0000000;
            acc_ff      <= 9'h000;
        end
        else if (nxt_state == ST_WAIT || nxt_state == ST_OFF || new_cycle)  // R16
        begin
            pre_cnt_ff  <= 24'h000000;
            fast_cnt_ff <= 24'h000000;
            added_ff    <= 25'h0000000;
            acc_ff      <= 9'h000;
        end
        else
        begin
            if (state_ff == ST_PRE && nxt_state == ST_FAST)
            begin
                added_ff <= 25'h0000000;  // R11
                acc_ff   <= 9'h000;
            end
            else if (base_tick_ff && !suspend && slowing)  // R9 R18
            begin
                acc_ff <= (acc_sum >= `CTT_LVL_FULL) ? acc_sum - `CTT_LVL_FULL : acc_sum;
                if (acc_sum < `CTT_LVL_FULL)
                begin
                    added_ff <= added_ff + 25'h0000001;  // R19
                end
            end
            if (timer_tick && state_ff == ST_PRE && !pre_exp)
            begin
                pre_cnt_ff <= pre_cnt_ff + 24'h000001;
            end
            if (float_s)
            begin
                fast_cnt_ff <= 24'h000000;  // R13
            end
            else if (timer_tick && state_ff == ST_FAST && !fast_exp)
            begin
                fast_cnt_ff <= fast_cnt_ff + 24'h000001;
            end
        end
    end

    // Charger outputs and state code
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            charge_on_o         <= 1'b0;
            hv_charge_o         <= 1'b0;
            current_scale_o     <= 2'h3;
            low_power_off_o     <= 1'b1;
            charge_state_high_o <= 1'b0;
            charge_state_low_o  <= 1'b0;
            fault_o             <= 1'b0;
        end
        else
        begin
            charge_on_o     <= (nxt_state == ST_PRE || nxt_state == ST_FAST) & ~suspend;
            hv_charge_o     <= ctrl_ff[`CTT_CTRL_HV] & ~ctrl_ff[`CTT_CTRL_VSAFE];  // R6
            current_scale_o <= {ctrl_ff[`CTT_CTRL_SCL_MSB], ctrl_ff[`CTT_CTRL_SCL_LSB]};  // R2
            low_power_off_o <= (nxt_state == ST_OFF);  // R7
            fault_o         <= (nxt_state == ST_FAULT);
            case (nxt_state)  // R21
                ST_PRE:
                begin
                    charge_state_high_o <= ~suspend;
                    charge_state_low_o  <= ~suspend;
                end
                ST_FAST:
                begin
                    charge_state_high_o <= ~suspend;
                    charge_state_low_o  <= 1'b0;
                end
                ST_DONE:
                begin
                    charge_state_high_o <= 1'b0;
                    charge_state_low_o  <= 1'b1;
                end
                default:
                begin
                    charge_state_high_o <= 1'b0;
                    charge_state_low_o  <= 1'b0;
                end
            endcase
        end
    end

    // Read port: data valid the cycle after the strobe, zero otherwise
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_o <= 8'h00;
        end
        else if (rd_i)
        begin
            case (addr_i)
                `CTT_OFS_CTRL:
                begin
                    rd_data_o <= {2'h0, ctrl_ff};
                end
                `CTT_OFS_STATUS:
                begin
                    rd_data_o <= {suspend, slowing, low_power_off_o, state_ff == ST_DONE,
                                  pullup_en_o, fault_o, charge_state_high_o,
                                  charge_state_low_o};
                end
                `CTT_OFS_PRE_CNT:
                begin
                    rd_data_o <= pre_cnt_ff[7:0];
                end
                `CTT_OFS_FAST_CNT:
                begin
                    rd_data_o <= fast_cnt_ff[15:8];
                end
                default:
                begin
                    rd_data_o <= 8'h00;
                end
            endcase
        end
        else
        begin
            rd_data_o <= 8'h00;
        end
    end

endmodule // ctt_charger_ctrl

//--- ctt_charger_ctrl_props.sv
module ctt_charger_ctrl_props #(
    parameter TICK_CYC     = 4,
    parameter INT_TICK_CYC = 4,
    parameter FAST_TICKS   = 20
) (
    // Clock, reset and register writes
    input wire       clock_i,
    input wire       rst_n_i,
    input wire [3:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire       wr_i,
    // Loop and supply status
    input wire       thermal_loop_i,
    input wire       input_droop_loop_i,
    input wire       supplement_i,
    input wire       ac_det_i,
    input wire       usb_det_i,
    input wire       uvlo_i,
    input wire       tmr_float_i,
    // Controls and status
    input wire       charge_on_o,
    input wire       hv_charge_o,
    input wire [1:0] current_scale_o,
    input wire       pullup_en_o,
    input wire       low_power_off_o,
    input wire       charge_state_high_o,
    input wire       charge_state_low_o,
    input wire       fault_o
);
    // Slowdown can at most triple fast time; tick phase adds slack
    localparam int FAST_MAX = 3 * FAST_TICKS * TICK_CYC + 2 * TICK_CYC;
    wire [1:0]  code = {charge_state_high_o, charge_state_low_o};
    reg  [31:0] fast_cyc_ff;
    default clocking dcb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Cycles in fast charge; a floating timer pin never times out
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fast_cyc_ff <= 32'h0;
        else if (code != 2'h2 || tmr_float_i)
            fast_cyc_ff <= 32'h0;
        else
            fast_cyc_ff <= fast_cyc_ff + 32'h1;
    end
    a_hv_select:
    assert property (wr_i && addr_i == 4'h0 |-> ##2
        hv_charge_o == ($past(wr_data_i[2], 2) && !$past(wr_data_i[5], 2)))
        else $error("hv select does not follow write");
    a_scale_follow:
    assert property (wr_i && addr_i == 4'h0 |-> ##2 current_scale_o == $past(wr_data_i[4:3], 2))
        else $error("scale code does not follow write");
    a_off_no_input:
    assert property ((!ac_det_i && !usb_det_i)[*8] |-> low_power_off_o && !charge_on_o)
        else $error("not off without input");
    a_uvlo_clear:
    assert property (uvlo_i[*8] |-> !fault_o && !pullup_en_o && low_power_off_o)
        else $error("lockout did not clear");
    a_fault_idle:
    assert property (fault_o |-> !charge_on_o && code == 2'h0)
        else $error("charging in fault");
    a_pullup_fault:
    assert property (pullup_en_o |-> fault_o)
        else $error("pullup outside fault");
    a_no_term_loop:
    assert property ((thermal_loop_i || input_droop_loop_i || supplement_i)[*8] ##1
        code == 2'h2 |=> code != 2'h1)
        else $error("terminated under loop");
    a_on_codes:
    assert property (charge_on_o |-> code[1])
        else $error("charging with idle code");
    a_fast_bound:
    assert property (fast_cyc_ff <= FAST_MAX)
        else $error("fast phase overran");
    a_pre_to_done:
    assert property (code == 2'h3 |=> code != 2'h1)
        else $error("done straight from pre");
endmodule // ctt_charger_ctrl_props

//--- ctt_analog_model.sv
module ctt_analog_model (
    // Clock of the behavioural cell
    input  wire       clock_i,
    // Charger side
    input  wire       charge_on_i,
    input  wire       pullup_en_i,
    input  wire [1:0] scale_i,
    // Bench knobs: stalled charge and heavy load
    input  wire       stall_i,
    input  wire       load_i,
    // Comparator levels
    output wire       vreg_phase_o,
    output wire       term_cmp_o,
    output wire       bat_below_rch_o,
    output wire       bat_above_pre_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cell in tenths of a volt; regulation at 42
    int bat = 20;
    int taper = 0;
    // Load wins over charge; a pullup lifts an emptied pin
    always @(posedge clock_i)
    begin
        if (load_i && bat > 20)
            bat <= bat - 1;
        else if ((pullup_en_i || (charge_on_i && !stall_i)) && bat < 42)
            bat <= bat + 1;
        taper <= (charge_on_i && bat >= 42) ? taper + 1 : 0;
    end
    // Current tapers in regulation; scale code moves the trip point
    assign vreg_phase_o    = bat >= 42;
    assign term_cmp_o      = vreg_phase_o && taper > 12 + int'(scale_i);
    assign bat_below_rch_o = bat < 38;
    assign bat_above_pre_o = bat > 25;
endmodule // ctt_analog_model

//--- ctt_charger_ctrl_tb_top.sv
module ctt_charger_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam TCK = 16;
    localparam FT  = 20;
    // Bench-driven inputs
    reg        clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    reg  [3:0] addr_i = 4'h0;
    reg  [7:0] wr_data_i = 8'h00, set_level_i = 8'hFF, d;
    reg        thermal_loop_i = 1'b0, input_droop_loop_i = 1'b0, supplement_i = 1'b0;
    reg        ac_det_i = 1'b0, usb_det_i = 1'b0, uvlo_i = 1'b0;
    reg        tmr_float_i = 1'b0, temp_fault_i = 1'b0, stall = 1'b0, load = 1'b0;
    reg [31:0] lfsr = 32'h69BE;
    // Design outputs and comparator lines
    wire [7:0] rd_data_o;
    wire [1:0] current_scale_o;
    wire       term_cmp_i, vreg_phase_i, bat_below_rch_i, bat_above_pre_i;
    wire       charge_on_o, hv_charge_o, pullup_en_o, low_power_off_o;
    wire       charge_state_high_o, charge_state_low_o, fault_o;
    wire [1:0] code = {charge_state_high_o, charge_state_low_o};
    int        fail_count = 0;
    int        check_count = 0;

    ctt_charger_ctrl #(.TICK_CYC(TCK), .INT_TICK_CYC(TCK), .FAST_TICKS(FT)) DUT (
        .clock_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .term_cmp_i,
        .vreg_phase_i, .bat_below_rch_i, .bat_above_pre_i, .thermal_loop_i,
        .input_droop_loop_i, .supplement_i, .ac_det_i, .usb_det_i, .uvlo_i, .tmr_float_i,
        .temp_fault_i, .set_level_i, .charge_on_o, .hv_charge_o, .current_scale_o,
        .pullup_en_o, .low_power_off_o, .charge_state_high_o, .charge_state_low_o, .fault_o);
    ctt_analog_model u_model (.clock_i, .charge_on_i(charge_on_o), .pullup_en_i(pullup_en_o),
        .scale_i(current_scale_o), .stall_i(stall), .load_i(load), .vreg_phase_o(vreg_phase_i),
        .term_cmp_o(term_cmp_i), .bat_below_rch_o(bat_below_rch_i),
        .bat_above_pre_o(bat_above_pre_i));

    // 125 MHz
    always #4 clock_i = ~clock_i;
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random set-pin level; only bites while a loop slows the timers
    always @(posedge clock_i)
    begin
        lfsr <= lfsr_next(lfsr);
        set_level_i <= lfsr[7:0];
    end

    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task chb(input string nm, input seen, input exp);
        chk(nm, {7'h00, seen}, {7'h00, exp});
    endtask
    task wr(input [3:0] a, input [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input [3:0] a, input [7:0] exp, input string nm);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(nm, rd_data_o, exp);
    endtask
    // Bounded wait for a state code
    task wcode(input [1:0] c, input int n);
        repeat (n)
        begin
            @(posedge clock_i);
            #1;
            if (code === c)
                break;
        end
        chk("state code", {6'h00, code}, {6'h00, c});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog well past the expected run of under two thousand cycles
    initial
    begin
        repeat (30000) @(posedge clock_i);
        fail_count++;
        close_out;
    end

    initial
    begin
        cyc(3);
        chk("scale in reset", {6'h00, current_scale_o}, 8'h03);
        chb("off in reset", low_power_off_o, 1'b1);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(4'h0, 8'h23, "ctrl reset");
        // Every scale code against every select and safety pairing
        for (int i = 0; i < 16; i++)
        begin
            d = {2'h0, i[3], i[1:0], i[2], 2'h3};
            wr(4'h0, d);
            cyc(1);
            chk("scale", {6'h00, current_scale_o}, {6'h00, d[4:3]});
            chb("hv", hv_charge_o, d[2] & ~d[5]);
            rd(4'h0, d, "ctrl");
        end
        wr(4'h4, 8'hFF);
        rd(4'h2, 8'h00, "unmapped");
        rd(4'h0, d, "ctrl after status write");
        wr(4'h0, 8'h1B);
        // Plain cycle, then recharge on a sagging cell
        ac_det_i <= 1'b1;
        wcode(2'h3, 40);
        chb("on in pre", charge_on_o, 1'b1);
        wcode(2'h2, 40);
        wcode(2'h1, 200);
        load <= 1'b1;
        wcode(2'h2, 60);
        load <= 1'b0;
        // Loops hold off termination until they drop
        thermal_loop_i <= 1'b1;
        input_droop_loop_i <= 1'b1;
        cyc(80);
        chk("code under loop", {6'h00, code}, 8'h02);
        thermal_loop_i <= 1'b0;
        input_droop_loop_i <= 1'b0;
        wcode(2'h1, 200);
        // Lockout while the cell drains, then a stalled pre-charge
        uvlo_i <= 1'b1;
        load <= 1'b1;
        stall <= 1'b1;
        cyc(40);
        chb("off in lockout", low_power_off_o, 1'b1);
        load <= 1'b0;
        uvlo_i <= 1'b0;
        wcode(2'h3, 20);
        cyc(10);
        chb("fault early", fault_o, 1'b0);
        wcode(2'h0, 40);
        chb("pre timeout", fault_o, 1'b1);
        chb("pullup on", pullup_en_o, 1'b1);
        cyc(40);
        chb("pullup off", pullup_en_o, 1'b0);
        chb("fault held", fault_o, 1'b1);
        load <= 1'b1;
        cyc(8);
        load <= 1'b0;
        wcode(2'h2, 40);
        chb("fault cleared", fault_o, 1'b0);
        // Suspend mid fast charge must freeze, not restart, the timer
        cyc(150 + int'(lfsr[3:0]));
        temp_fault_i <= 1'b1;
        wcode(2'h0, 10);
        chb("off in suspend", charge_on_o, 1'b0);
        cyc(300);
        temp_fault_i <= 1'b0;
        wcode(2'h2, 10);
        cyc(100);
        chb("fault frozen", fault_o, 1'b0);
        wcode(2'h0, 120);
        chb("fast timeout", fault_o, 1'b1);
        wr(4'h0, 8'h19);
        wr(4'h0, 8'h1B);
        cyc(8);
        chb("fault after toggle", fault_o, 1'b0);
        chb("pullup after toggle", pullup_en_o, 1'b0);
        // Both inputs gone, then one returns
        stall <= 1'b0;
        tmr_float_i <= 1'b1;
        supplement_i <= 1'b1;
        ac_det_i <= 1'b0;
        cyc(10);
        chb("no input off", low_power_off_o, 1'b1);
        chk("no input code", {6'h00, code}, 8'h00);
        usb_det_i <= 1'b1;
        cyc(10);
        chb("usb back", low_power_off_o, 1'b0);
        close_out;
    end
endmodule // ctt_charger_ctrl_tb_top

bind ctt_charger_ctrl ctt_charger_ctrl_props #(.TICK_CYC(TICK_CYC),
    .INT_TICK_CYC(INT_TICK_CYC), .FAST_TICKS(FAST_TICKS)) u_props (
    .clock_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .thermal_loop_i, .input_droop_loop_i,
    .supplement_i, .ac_det_i, .usb_det_i, .uvlo_i, .tmr_float_i, .charge_on_o, .hv_charge_o,
    .current_scale_o, .pullup_en_o, .low_power_off_o, .charge_state_high_o,
    .charge_state_low_o, .fault_o);
